// [src/sbcgp_regs.sv]
// Top of the general purpose register bank of the supervisory chip.
// Software sends 16-bit access frames over APB and reads their answers.
// Assumes an APB master on i_clock and partner feedback words on i_clock.
//
// Overview of operation
// - Threshold code 11/10/01/00 gives 90/70/80/90 percent
// - Two 12-bit scratch registers with feedback copies
// - Power-up loads scratch zero with identification code
// - Identification code stays until host overwrites
// - Power-up clears the identification-content flag
// - Any scratch-zero write sets the flag
// - Flag bit 11: one user, zero identification
// - Scratch zero bits 10:0 store user value
// - Address 10: select one own copy, zero configuration
// - Scratch zero: read-only bit blocks the write
// - Address 11 targets scratch register one
// - Scratch one: select one own, zero layer control
// - Scratch one: read-only bit blocks the write
// - Scratch one stores all twelve user bits
// - Address 01 targets the special-mode register
// - Special mode: select one own, zero interrupt enable
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
module sbcgp_regs
#(
    // Identification code fields, values are arbitrary
    parameter logic [6:0] CHIP_TYPE    = 7'h2A,
    parameter logic [3:0] CHIP_VERSION = 4'h1
)
(
    // Clock and reset
    input  wire logic                              i_clock,
    input  wire logic                              i_resetn,
    // APB slave
    input  wire logic                              i_psel,
    input  wire logic                              i_penable,
    input  wire logic                              i_pwrite,
    input  wire logic [sbcgp_pkg::APB_AW-1:0]      i_paddr,
    input  wire logic [sbcgp_pkg::APB_DW-1:0]      i_pwdata,
    input  wire logic [3:0]                        i_pstrb,
    output logic      [sbcgp_pkg::APB_DW-1:0]      o_prdata,
    output logic                                   o_pready,
    output logic                                   o_pslverr,
    // Partner feedback words
    input  wire logic [sbcgp_pkg::REG_W-1:0]       i_sysconf_feedback,
    input  wire logic [sbcgp_pkg::REG_W-1:0]       i_int_enable_feedback,
    input  wire logic [sbcgp_pkg::REG_W-1:0]       i_phy_ctrl_feedback,
    // Bank outputs
    output logic      [sbcgp_pkg::REG_W-1:0]       o_special_mode,
    output logic      [sbcgp_pkg::THR_SEL_W-1:0]   o_supply_reset_threshold_sel,
    output logic      [6:0]                        o_reset_threshold_pct,
    output logic                                   o_ident_content_flag,
    output logic                                   o_frame_done
);

    // Power-up content of scratch zero: flag clear, type and version
    localparam logic [sbcgp_pkg::REG_W-1:0] SCRATCH0_RST = {1'b0, CHIP_TYPE, CHIP_VERSION};

    // Bank state
    logic [sbcgp_pkg::REG_W-1:0] special_reg;       // Special-mode register
    logic [sbcgp_pkg::REG_W-1:0] special_next;
    logic [sbcgp_pkg::REG_W-1:0] scratch0_reg;      // Scratch zero with flag
    logic [sbcgp_pkg::REG_W-1:0] scratch0_next;
    logic [sbcgp_pkg::REG_W-1:0] scratch1_reg;      // Scratch one
    logic [sbcgp_pkg::REG_W-1:0] scratch1_next;
    logic [sbcgp_pkg::REG_W-1:0] response_reg;      // Answer of last frame
    logic [sbcgp_pkg::REG_W-1:0] response_next;
    logic [15:0]                 frame_reg;         // Last frame taken
    logic [15:0]                 frame_next;
    logic [6:0]                  thr_pct_reg;       // Decoded threshold
    logic [6:0]                  thr_pct_next;
    logic                        done_reg;          // Frame taken pulse
    logic                        done_next;

    // APB answer state
    logic [sbcgp_pkg::APB_DW-1:0] prdata_reg;
    logic [sbcgp_pkg::APB_DW-1:0] prdata_next;
    logic                         pready_reg;
    logic                         pready_next;
    logic                         pslverr_reg;
    logic                         pslverr_next;

    // Frame path
    sbcgp_pkg::sbcgp_frame_s  wr_frame;     // Frame on the write bus
    sbcgp_pkg::sbcgp_decode_s decode;       // Its decode
    logic                     access_done;  // APB completion edge
    logic                     strb_ok;      // Frame carries exactly the two low lanes
    logic                     frame_strobe; // Frame takes effect now

    assign wr_frame     = sbcgp_pkg::sbcgp_frame_s'(i_pwdata[15:0]);
    assign access_done  = i_psel && i_penable && pready_reg;
    assign strb_ok      = (i_pstrb == sbcgp_pkg::FRAME_STRB);
    // A partial-lane frame would tear the header from the data, so drop it
    assign frame_strobe = access_done && i_pwrite && strb_ok
                          && (i_paddr == sbcgp_pkg::OFS_FRAME);

    // Frame decoder
    sbcgp_frame_unit u_frame_unit
    (
        .i_frame               (wr_frame),
        .i_special             (special_reg),
        .i_scratch0            (scratch0_reg),
        .i_scratch1            (scratch1_reg),
        .i_sysconf_feedback    (i_sysconf_feedback),
        .i_int_enable_feedback (i_int_enable_feedback),
        .i_phy_ctrl_feedback   (i_phy_ctrl_feedback),
        .o_decode              (decode)
    );

    // Bank next state; answer holds contents from before the write,
    // as a shift frame would return them
    always_comb
    begin
        special_next  = special_reg;
        scratch0_next = scratch0_reg;
        scratch1_next = scratch1_reg;
        response_next = response_reg;
        frame_next    = frame_reg;
        done_next     = frame_strobe;
        if (frame_strobe)
        begin
            frame_next    = i_pwdata[15:0];
            response_next = decode.response;
            if (decode.wr_special)
            begin
                // Reserved bits are stored as sent
                special_next = wr_frame.payload;
            end
            if (decode.wr_scratch0)
            begin
                // Written flag value is ignored, any write marks user content
                scratch0_next = {1'b1, wr_frame.payload[sbcgp_pkg::USER0_W-1:0]};
            end
            if (decode.wr_scratch1)
            begin
                scratch1_next = wr_frame.payload;
            end
        end
        thr_pct_next = sbcgp_pkg::thr_pct(
            special_next[sbcgp_pkg::THR_SEL_LSB +: sbcgp_pkg::THR_SEL_W]);
    end

    // Bank registers
    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            special_reg  <= sbcgp_pkg::SPECIAL_RST;
            scratch0_reg <= SCRATCH0_RST;
            scratch1_reg <= sbcgp_pkg::SCRATCH1_RST;
            response_reg <= '0;
            frame_reg    <= '0;
            thr_pct_reg  <= sbcgp_pkg::thr_pct(
                sbcgp_pkg::SPECIAL_RST[sbcgp_pkg::THR_SEL_LSB +: sbcgp_pkg::THR_SEL_W]);
            done_reg     <= 1'b0;
        end
        else
        begin
            special_reg  <= special_next;
            scratch0_reg <= scratch0_next;
            scratch1_reg <= scratch1_next;
            response_reg <= response_next;
            frame_reg    <= frame_next;
            thr_pct_reg  <= thr_pct_next;
            done_reg     <= done_next;
        end
    end

    // APB answer: one wait state, data and error are ready with pready
    always_comb
    begin
        pready_next  = i_psel && i_penable && !pready_reg;
        prdata_next  = '0;
        pslverr_next = 1'b0;
        if (pready_next)
        begin
            unique case (i_paddr)
                sbcgp_pkg::OFS_FRAME:
                begin
                    prdata_next  = {16'h0000, frame_reg};
                    pslverr_next = i_pwrite && !strb_ok;
                end
                sbcgp_pkg::OFS_RESPONSE:
                begin
                    // Answer word is read only
                    prdata_next  = {20'h00000, response_reg};
                    pslverr_next = i_pwrite;
                end
                sbcgp_pkg::OFS_STATUS:
                begin
                    prdata_next[sbcgp_pkg::STAT_THR_LSB +: sbcgp_pkg::THR_SEL_W] =
                        special_reg[sbcgp_pkg::THR_SEL_LSB +: sbcgp_pkg::THR_SEL_W];
                    prdata_next[sbcgp_pkg::STAT_IDENT_BIT] =
                        scratch0_reg[sbcgp_pkg::IDENT_FLAG_BIT];
                    pslverr_next = i_pwrite;
                end
                default:
                begin
                    // Unmapped: zero data and an error
                    pslverr_next = 1'b1;
                end
            endcase
        end
    end

    // APB answer registers
    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Outputs straight from flops
    assign o_prdata                     = prdata_reg;
    assign o_pready                     = pready_reg;
    assign o_pslverr                    = pslverr_reg;
    assign o_special_mode               = special_reg;
    assign o_supply_reset_threshold_sel =
        special_reg[sbcgp_pkg::THR_SEL_LSB +: sbcgp_pkg::THR_SEL_W];
    assign o_reset_threshold_pct        = thr_pct_reg;
    assign o_ident_content_flag         = scratch0_reg[sbcgp_pkg::IDENT_FLAG_BIT];
    assign o_frame_done                 = done_reg;

    // Checks of the bank behaviour
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    // Frame to a given target; wr_s0 and wr_s1 also need write allowed
    logic wr_s0;
    logic wr_s1;
    logic rd_s0;
    assign wr_s0 = frame_strobe && (wr_frame.frame_reg_addr == sbcgp_pkg::FADDR_SCRATCH0)
                   && !wr_frame.read_without_write;
    assign wr_s1 = frame_strobe && (wr_frame.frame_reg_addr == sbcgp_pkg::FADDR_SCRATCH1)
                   && !wr_frame.read_without_write;
    assign rd_s0 = frame_strobe && (wr_frame.frame_reg_addr == sbcgp_pkg::FADDR_SCRATCH0);

    a_thr_decode: assert property (
        o_reset_threshold_pct == sbcgp_pkg::thr_pct(o_supply_reset_threshold_sel))
        else $error("threshold percent does not match select code");

    a_ident_powerup: assert property (
        !$past(i_resetn) |-> (scratch0_reg == SCRATCH0_RST) && !o_ident_content_flag)
        else $error("scratch zero lacks identification code after reset");

    a_ident_kept: assert property (
        !o_ident_content_flag && !wr_s0 |=> !o_ident_content_flag && $stable(scratch0_reg))
        else $error("identification code lost without a write");

    a_flag_set: assert property (
        wr_s0 |=> o_ident_content_flag && o_frame_done)
        else $error("flag not set by scratch zero write");

    a_s0_store: assert property (
        wr_s0 |=> scratch0_reg[sbcgp_pkg::USER0_W-1:0] == $past(i_pwdata[10:0]))
        else $error("scratch zero user bits not stored");

    a_ro_blocks: assert property (
        frame_strobe && wr_frame.read_without_write
        |=> $stable(scratch0_reg) && $stable(scratch1_reg) && $stable(special_reg))
        else $error("read only frame changed a register");

    a_s1_store: assert property (
        wr_s1 |=> scratch1_reg == $past(i_pwdata[11:0]))
        else $error("scratch one not stored");

    a_s0_answer: assert property (
        rd_s0 |=> response_reg == ($past(wr_frame.readback_select) ? $past(scratch0_reg)
                                                                   : $past(i_sysconf_feedback)))
        else $error("wrong answer for scratch zero frame");

    a_done_pulse: assert property (
        frame_strobe |=> o_frame_done ##1 !o_frame_done || $past(frame_strobe))
        else $error("frame done pulse wrong");

    a_apb_wait: assert property (
        i_psel && i_penable && !o_pready |=> o_pready)
        else $error("slave did not answer after one wait state");

    c_ident_overwrite: cover property (!o_ident_content_flag ##1 wr_s0 ##1 o_ident_content_flag);
    c_ro_frame:        cover property (frame_strobe && wr_frame.read_without_write);
    c_s1_write:        cover property (wr_s1);
    c_unmapped:        cover property (o_pready && o_pslverr);

endmodule

// [src/sbcgp_pkg.sv]
// Package for the general purpose register bank of the supervisory chip.
// Holds the APB map, the frame layout, field positions and reset values.
// Assumes the including logic runs on one clock and uses package::name.
package sbcgp_pkg;

    // APB address width and data width
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;

    // Byte addresses of the APB visible words
    localparam logic [APB_AW-1:0] OFS_FRAME    = 12'h000;  // Frame in, last frame out
    localparam logic [APB_AW-1:0] OFS_RESPONSE = 12'h004;  // Answer of the last frame
    localparam logic [APB_AW-1:0] OFS_STATUS   = 12'h008;  // Live bank state

    // Byte strobes a frame write must carry (frame sits in the low half)
    localparam logic [3:0] FRAME_STRB = 4'h3;

    // Frame address codes
    localparam logic [1:0] FADDR_SPECIAL  = 2'h1;
    localparam logic [1:0] FADDR_SCRATCH0 = 2'h2;
    localparam logic [1:0] FADDR_SCRATCH1 = 2'h3;

    // Register data width
    localparam int REG_W = 12;

    // Field positions inside the special-mode register
    localparam int THR_SEL_LSB = 3;
    localparam int THR_SEL_W   = 2;

    // Field positions inside scratch register 0
    localparam int IDENT_FLAG_BIT = 11;
    localparam int USER0_W        = 11;

    // Field positions inside the status word
    localparam int STAT_THR_LSB   = 0;
    localparam int STAT_IDENT_BIT = 2;

    // Reset values
    localparam logic [REG_W-1:0] SPECIAL_RST  = 12'h000;
    localparam logic [REG_W-1:0] SCRATCH1_RST = 12'h000;

    // Supply reset threshold in percent of nominal supply
    localparam logic [6:0] THR_PCT_90 = 7'h5A;
    localparam logic [6:0] THR_PCT_80 = 7'h50;
    localparam logic [6:0] THR_PCT_70 = 7'h46;

    // One access frame as the host shapes it
    typedef struct packed {
        logic [1:0]       frame_reg_addr;      // Target register
        logic             readback_select;     // 1: own copy, 0: partner feedback
        logic             read_without_write;  // 1: read only
        logic [REG_W-1:0] payload;             // Data for the target
    } sbcgp_frame_s;

    // Result of decoding one frame
    typedef struct packed {
        logic             wr_special;
        logic             wr_scratch0;
        logic             wr_scratch1;
        logic [REG_W-1:0] response;
    } sbcgp_decode_s;

    // Threshold select code to percent of nominal supply
    function automatic logic [6:0] thr_pct(input logic [THR_SEL_W-1:0] sel);
        logic [6:0] pct;
        pct = THR_PCT_90;
        unique case (sel)
            2'h3: pct = THR_PCT_90;
            2'h2: pct = THR_PCT_70;
            2'h1: pct = THR_PCT_80;
            2'h0: pct = THR_PCT_90;
        endcase
        return pct;
    endfunction

endpackage

// [src/sbcgp_frame_unit.sv]
// Frame decoder of the general purpose register bank.
// Purely combinational: the caller qualifies the write enables with its
// own frame strobe and registers the answer.
`timescale 1ns/1ps
module sbcgp_frame_unit
(
    // Incoming frame
    input  wire sbcgp_pkg::sbcgp_frame_s          i_frame,
    // Stored copies of the bank
    input  wire logic [sbcgp_pkg::REG_W-1:0]      i_special,
    input  wire logic [sbcgp_pkg::REG_W-1:0]      i_scratch0,
    input  wire logic [sbcgp_pkg::REG_W-1:0]      i_scratch1,
    // Feedback words of partner registers
    input  wire logic [sbcgp_pkg::REG_W-1:0]      i_sysconf_feedback,
    input  wire logic [sbcgp_pkg::REG_W-1:0]      i_int_enable_feedback,
    input  wire logic [sbcgp_pkg::REG_W-1:0]      i_phy_ctrl_feedback,
    // Decode result
    output sbcgp_pkg::sbcgp_decode_s              o_decode
);

    // Write is allowed unless the frame asks for read only
    logic write_ok;
    assign write_ok = !i_frame.read_without_write;

    // Target decode and answer select
    always_comb
    begin
        o_decode = '0;
        unique case (i_frame.frame_reg_addr)
            sbcgp_pkg::FADDR_SPECIAL:
            begin
                o_decode.wr_special = write_ok;
                o_decode.response   = i_frame.readback_select ? i_special
                                                              : i_int_enable_feedback;
            end
            sbcgp_pkg::FADDR_SCRATCH0:
            begin
                o_decode.wr_scratch0 = write_ok;
                o_decode.response    = i_frame.readback_select ? i_scratch0
                                                               : i_sysconf_feedback;
            end
            sbcgp_pkg::FADDR_SCRATCH1:
            begin
                o_decode.wr_scratch1 = write_ok;
                o_decode.response    = i_frame.readback_select ? i_scratch1
                                                               : i_phy_ctrl_feedback;
            end
            default:
            begin
                // Code 00 belongs to another bank: answer zero, write nothing
                o_decode = '0;
            end
        endcase
    end

endmodule

// [verif/sbcgp_feedback_model.sv]
// Stand-in for the partner registers whose feedback words the bank returns.
// Assumes the bench reads the same parameters to predict the answers.
`timescale 1ns/1ps
module sbcgp_feedback_model
#(
    // Distinct words so a wrong selection shows at once
    parameter logic [11:0] SYS_WORD = 12'hC35,
    parameter logic [11:0] INT_WORD = 12'h6A9,
    parameter logic [11:0] PHY_WORD = 12'h1E7
)
(
    // Feedback words toward the bank
    output logic [11:0] o_sysconf_feedback,
    output logic [11:0] o_int_enable_feedback,
    output logic [11:0] o_phy_ctrl_feedback
);
    // Static levels: the partner registers do not change during these tests
    always_comb
    begin
        o_sysconf_feedback    = SYS_WORD;
        o_int_enable_feedback = INT_WORD;
        o_phy_ctrl_feedback   = PHY_WORD;
    end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the general purpose register bank.
// Assumes the APB slave answers with pready and a partner model feeds words.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value %s exp %h got %h", what, exp, got); end end
module tb_top;
    // Identification code, arbitrary values shared with the design instance
    localparam logic [6:0]  CT = 7'h2A;
    localparam logic [3:0]  CV = 4'h1;
    localparam logic [11:0] FB_SYS = 12'hC35;  // Partner words, arbitrary
    localparam logic [11:0] FB_INT = 12'h6A9;
    localparam logic [11:0] FB_PHY = 12'h1E7;
    // Bus and bank signals
    logic        i_clock, i_resetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, fb_sys, fb_int, fb_phy, special;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [1:0]  thr;
    logic [6:0]  pct;
    logic        flag, done, err, dn;
    // Expected contents kept by the bench
    logic [11:0] sp, s0, s1, e;
    logic [15:0] lastf;
    int          num_errors, n_checks, cycles;

    sbcgp_feedback_model #(.SYS_WORD(FB_SYS), .INT_WORD(FB_INT), .PHY_WORD(FB_PHY)) i_fb
        (.o_sysconf_feedback(fb_sys), .o_int_enable_feedback(fb_int),
         .o_phy_ctrl_feedback(fb_phy));
    sbcgp_regs #(.CHIP_TYPE(CT), .CHIP_VERSION(CV)) i_dut
        (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable),
         .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
         .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
         .i_sysconf_feedback(fb_sys), .i_int_enable_feedback(fb_int),
         .i_phy_ctrl_feedback(fb_phy), .o_special_mode(special),
         .o_supply_reset_threshold_sel(thr), .o_reset_threshold_pct(pct),
         .o_ident_content_flag(flag), .o_frame_done(done));

    // Free running clock, 40 ns period
    initial
    begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    // Hang guard: the sequence needs well under a thousand cycles
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            $display("wrong value timeout exp %h got %h", 1'b0, 1'b1);
            test_done();
        end
    end

    // Verdict and end of run
    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One APB transfer; holds everything until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge i_clock);
        penable <= 1'b1;
        // Wait as long as the slave needs; only the hang guard ends a stuck wait
        do
        begin
            @(posedge i_clock);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle cycle so no signal is assigned twice in one step; done pulses here
        @(posedge i_clock);
        dn = done;
    endtask

    // Send a frame, read its answer, then compare live outputs with the model
    task automatic frame(input logic [1:0] a, input logic rs, input logic ro,
                         input logic [11:0] pl);
        case (a)
            2'h1:    e = rs ? sp : FB_INT;
            2'h2:    e = rs ? s0 : FB_SYS;
            2'h3:    e = rs ? s1 : FB_PHY;
            default: e = 12'h000;  // Address 00 is outside this bank
        endcase
        lastf = {a, rs, ro, pl};
        // Upper half carries junk on purpose: it must be ignored
        apb(1'b1, 12'h000, {16'hA5A5, lastf}, 4'h3);
        `CHK("frame err", 1'b0, err)
        `CHK("frame done", 1'b1, dn)
        if (!ro)
        begin
            if (a == 2'h1) sp = pl;
            if (a == 2'h2) s0 = {1'b1, pl[10:0]};  // Flag forced by any write
            if (a == 2'h3) s1 = pl;
        end
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        `CHK("response", {20'h0, e}, rd)
        `CHK("special", sp, special)
        `CHK("threshold", sp[4:3], thr)
        `CHK("pct", (sp[4:3] == 2'h2) ? 7'h46 : (sp[4:3] == 2'h1) ? 7'h50 : 7'h5A, pct)
        `CHK("ident flag", s0[11], flag)
    endtask

    // Main sequence
    initial
    begin
        i_resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        repeat (6) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        sp = 12'h000;
        s0 = {1'b0, CT, CV};
        s1 = 12'h000;
        apb(1'b0, 12'h008, 32'h0, 4'h0);
        `CHK("status", 32'h0, rd)
        `CHK("pct", 7'h5A, pct)
        // Read-only frames of every address and select leave the bank alone
        for (int r = 0; r < 2; r++)
            for (int a = 0; a < 4; a++)
                frame(2'(a), 1'(r), 1'b1, 12'hFFF);
        // Every threshold code, reserved bits kept at zero
        for (int c = 0; c < 4; c++)
            frame(2'h1, 1'b1, 1'b0, 12'(c << 3));
        frame(2'h1, 1'b1, 1'b1, 12'h000);
        frame(2'h2, 1'b1, 1'b0, 12'h3FF);
        frame(2'h2, 1'b1, 1'b0, 12'h800);
        frame(2'h2, 1'b1, 1'b1, 12'hFFF);
        frame(2'h3, 1'b1, 1'b0, 12'hFFF);
        frame(2'h3, 1'b0, 1'b0, 12'h5A5);
        frame(2'h3, 1'b1, 1'b1, 12'h000);
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        `CHK("last frame", {16'h0, lastf}, rd)
        // Refused accesses change nothing
        // Would rewrite special mode if taken; the next frame's checks would show it
        apb(1'b1, 12'h000, 32'h0000_4FFF, 4'hF);
        `CHK("strobe err", 1'b1, err)
        `CHK("strobe done", 1'b0, dn)
        apb(1'b1, 12'h004, 32'h0, 4'hF);
        `CHK("ro err", 1'b1, err)
        apb(1'b1, 12'h008, 32'h0000_0FFF, 4'hF);
        `CHK("status wr err", 1'b1, err)
        apb(1'b0, 12'h010, 32'h0, 4'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        frame(2'h2, 1'b1, 1'b1, 12'h000);
        apb(1'b0, 12'h008, 32'h0, 4'h0);
        `CHK("status", {29'h0, s0[11], sp[4:3]}, rd)
        // Second reset in mid-run brings the code back
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        sp = 12'h000;
        s0 = {1'b0, CT, CV};
        s1 = 12'h000;
        frame(2'h2, 1'b1, 1'b1, 12'h000);
        test_done();
    end
endmodule
